//--- hdl/frame_buffer_overflow_ctrl.sv
// Frame buffer with fill-level overflow supervision and APB registers
module frame_buffer_overflow_ctrl
  import fbo_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Camera stream in
  input  wire logic              in_valid,
  input  wire logic              in_sof,
  input  wire logic              in_eof,
  input  wire logic [15:0]       in_frame_id,
  input  wire logic [DATA_W-1:0] in_data,
  // Stream toward the DMA engine
  output logic                   out_valid,
  input  wire logic              out_ready,
  output beat_t                  out_beat,
  // Overflow events
  output logic                   evt_valid,
  output event_t                 evt
);

  // ---- Buffer signals
  logic             fifo_wr_valid;  // Push into the buffer
  logic             fifo_wr_ready;  // Buffer has a free word
  beat_t            fifo_wr_data;   // Word being pushed
  logic             fifo_rd_valid;  // Buffer holds a word
  logic             fifo_rd_ready;  // Output stage takes it
  beat_t            fifo_rd_data;   // Word at the head
  logic [CNT_W-1:0] fifo_count;     // Words stored

  // ---- Register state
  logic [7:0]       exit_q;         // Exit level, half percent
  logic [7:0]       entry_q;        // Immediate entry level
  logic [7:0]       sync_q;         // Frame-aligned entry level
  logic [2:0]       ev_en_q;        // Event kinds enabled
  logic             flag_q;         // Sticky buffer-full flag
  logic             flag_d;

  // ---- Supervisor state
  ovf_state_t       state_q;
  ovf_state_t       state_d;
  logic             storing_q;      // Current frame is being kept
  logic             term_pend_q;    // Closing word owed to a cut frame
  logic [15:0]      fid_q;          // Identity of the frame in flight
  logic [31:0]      stamp_q;        // Free-running time base

  // ---- Output stage
  logic             out_valid_q;
  beat_t            out_beat_q;
  logic             evt_valid_q;
  event_t           evt_q;

  // ---- APB stage
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;

  // The 16-word buffer between camera and DMA
  beat_fifo #(
    .W     ($bits(beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (pclk),
    .rst_n    (presetn),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (fifo_wr_data),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .count    (fifo_count)
  );

  // ---- Occupancy against the levels
  logic       above_entry;  // Immediate entry reached
  logic       above_sync;   // Frame-aligned entry reached
  logic       below_sync;   // Fell under frame-aligned level
  logic       below_exit;   // Fell under exit level
  logic [6:0] fill_pct;     // Integer percent, rounded down

  // Levels use the exact word count, only the report is rounded
  assign above_entry = lvl_above(fifo_count, entry_q);
  assign above_sync  = lvl_above(fifo_count, sync_q);
  assign below_sync  = lvl_below(fifo_count, sync_q);
  assign below_exit  = lvl_below(fifo_count, exit_q);
  assign fill_pct    = 7'((12'(fifo_count) * PCT_FULL) / DEPTH_W);

  // ---- Per-beat decisions
  logic beat_sof;   // Frame start beat offered
  logic beat_mid;   // Any later beat offered
  logic room;       // A data word may go in now
  logic imm_over;   // Must stop storing at once
  logic lost_hit;   // Whole frame discarded
  logic start_ok;   // Frame start kept
  logic trunc_hit;  // Frame cut partway
  logic mid_ok;     // Later beat kept
  logic push_data;  // Camera word goes in
  logic ends_ok;    // Frame closed complete
  logic term_push;  // Closing word for a cut frame

  // The closing word of a cut frame goes ahead of new data
  assign room      = fifo_wr_ready & ~term_pend_q;
  // No room at all is overflow whatever the levels say; a declared overflow
  // also cuts a frame that paused in a gap while the level was crossed
  assign imm_over  = above_entry | ~room | (state_q == ST_OVF);
  assign beat_sof  = in_valid & in_sof;
  assign beat_mid  = in_valid & ~in_sof;
  // Any state but run turns a new frame away entirely
  assign lost_hit  = beat_sof & ((state_q != ST_RUN) | imm_over);
  assign start_ok  = beat_sof & ~lost_hit;
  assign trunc_hit = beat_mid & storing_q & imm_over;
  assign mid_ok    = beat_mid & storing_q & ~imm_over;
  assign push_data = start_ok | mid_ok;
  assign ends_ok   = push_data & in_eof;
  assign term_push = term_pend_q & fifo_wr_ready;

  // ---- Buffer write word
  beat_t data_beat;  // Camera word as stored
  beat_t term_beat;  // Payload-free end marker

  assign data_beat.pad        = 1'b0;
  assign data_beat.incomplete = 1'b0;
  assign data_beat.sof        = in_sof;
  assign data_beat.eof        = in_eof;
  assign data_beat.data       = in_data;
  // Ends the shortened transfer and tags it incomplete
  assign term_beat.pad        = 1'b1;
  assign term_beat.incomplete = 1'b1;
  assign term_beat.sof        = 1'b0;
  assign term_beat.eof        = 1'b1;
  assign term_beat.data       = '0;
  assign fifo_wr_valid        = push_data | term_push;
  assign fifo_wr_data         = term_push ? term_beat : data_beat;

  // ---- Event contents
  logic        evt_fire;  // An enabled event happens now
  logic [15:0] evt_fid;   // Frame it concerns
  logic [63:0] evt_pkt;   // Packed event word

  // Lost comes only on a start beat, truncated only on a later one
  assign evt_fire = (lost_hit & ev_en_q[EV_LOST])
                  | (trunc_hit & ev_en_q[EV_TRUNC])
                  | (ends_ok & ev_en_q[EV_OK]);
  assign evt_fid  = in_sof ? in_frame_id : fid_q;
  assign evt_pkt  = (64'(evt_fid) << FID_LSB)
                  | (64'(trunc_hit) << TRUNC_POS)
                  | (64'(lost_hit) << LOST_POS);

  // ---- Overflow state sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      // Normal flow
      ST_RUN: begin
        if (above_entry | trunc_hit | lost_hit) begin
          state_d = ST_OVF;
        end else if (above_sync & ~storing_q & ~start_ok) begin
          state_d = ST_SYNC;
        end
      end
      // Entered between frames, follows its own level
      ST_SYNC: begin
        if (above_entry) begin
          state_d = ST_OVF;
        end else if (below_sync | below_exit) begin
          state_d = ST_RUN;
        end
      end
      // Full overflow, held until the exit level
      ST_OVF: begin
        if (below_exit) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= ST_RUN;
    else          state_q <= state_d;
  end

  // Frame tracking: keep, cut or drop the frame in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storing_q <= 1'b0;
    end else if (start_ok) begin
      storing_q <= ~in_eof;
    end else if (trunc_hit | ends_ok) begin
      storing_q <= 1'b0;
    end
  end

  // A cut frame owes one closing word; it waits for room
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_pend_q <= 1'b0;
    end else if (trunc_hit) begin
      term_pend_q <= 1'b1;
    end else if (term_push) begin
      term_pend_q <= 1'b0;
    end
  end

  // Identity of the frame in flight, for events on later beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      fid_q <= '0;
    else if (beat_sof) fid_q <= in_frame_id;
  end

  // Time base that stamps each event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stamp_q <= '0;
    else          stamp_q <= stamp_q + 32'h1;
  end

  // Event output, one cycle per event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_valid_q <= 1'b0;
      evt_q       <= '0;
    end else begin
      evt_valid_q <= evt_fire;
      if (evt_fire) begin
        evt_q.stamp  <= stamp_q;
        evt_q.packet <= evt_pkt;
      end
    end
  end

  // ---- Output stage toward DMA
  // A register here keeps the drain port free of buffer read paths
  assign fifo_rd_ready = ~out_valid_q | out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_q <= 1'b0;
      out_beat_q  <= '0;
    end else if (fifo_rd_ready) begin
      out_valid_q <= fifo_rd_valid;
      out_beat_q  <= fifo_rd_data;
    end
  end

  // ---- APB decode
  logic setup;      // First cycle of a transfer
  logic apb_done;   // Access phase completes this edge
  logic wr_done;    // Write takes effect
  logic rd_done;    // Read completes
  logic hit_fill;
  logic hit_flag;
  logic hit_exit;
  logic hit_entry;
  logic hit_sync;
  logic hit_even;
  logic hit_state;
  logic hit_any;
  logic [31:0] rd_word;  // Word presented for a read

  assign setup     = psel & ~penable;
  assign apb_done  = psel & penable & pready_q;
  assign wr_done   = apb_done & pwrite;
  assign rd_done   = apb_done & ~pwrite;
  assign hit_fill  = (paddr == ADDR_FILL);
  assign hit_flag  = (paddr == ADDR_FLAG);
  assign hit_exit  = (paddr == ADDR_EXIT);
  assign hit_entry = (paddr == ADDR_ENTRY);
  assign hit_sync  = (paddr == ADDR_SYNC);
  assign hit_even  = (paddr == ADDR_EVEN);
  assign hit_state = (paddr == ADDR_STATE);
  assign hit_any   = hit_fill | hit_flag | hit_exit | hit_entry
                   | hit_sync | hit_even | hit_state;

  // Read mux; unused bits read zero
  assign rd_word = ({32{hit_fill}}  & 32'(fill_pct))
                 | ({32{hit_flag}}  & 32'(flag_q))
                 | ({32{hit_exit}}  & 32'(exit_q))
                 | ({32{hit_entry}} & 32'(entry_q))
                 | ({32{hit_sync}}  & 32'(sync_q))
                 | ({32{hit_even}}  & 32'(ev_en_q))
                 | ({32{hit_state}} & 32'({fifo_count, state_q}));

  // Bus answer: ready in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit_any;
      if (setup) prdata_q <= pwrite ? 32'h0 : rd_word;
    end
  end

  // Writable levels and event enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_q  <= EXIT_RST;
      entry_q <= ENTRY_RST;
      sync_q  <= SYNC_RST;
      ev_en_q <= EVEN_RST;
    end else if (wr_done) begin
      if (hit_exit)  exit_q  <= pwdata[7:0];
      if (hit_entry) entry_q <= pwdata[7:0];
      if (hit_sync)  sync_q  <= pwdata[7:0];
      if (hit_even)  ev_en_q <= pwdata[2:0];
    end
  end

  // Sticky flag: a new overflow wins over the clearing read.
  // Only a 1 that was actually returned is cleared, so an overflow
  // landing between the two bus phases is never lost.
  logic flag_set;
  logic flag_clr;

  assign flag_set = lost_hit | trunc_hit | (state_d == ST_OVF);
  assign flag_clr = rd_done & hit_flag & prdata_q[0];
  assign flag_d   = flag_set | (flag_q & ~flag_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= 1'b0;
    else          flag_q <= flag_d;
  end

  // ---- Outputs, all straight from flip-flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign out_valid = out_valid_q;
  assign out_beat  = out_beat_q;
  assign evt_valid = evt_valid_q;
  assign evt       = evt_q;

endmodule // frame_buffer_overflow_ctrl

//--- hdl/fbo_pkg.sv
// Constants, types and level helpers for the frame buffer overflow controller
// Functional notes
// - Forward camera data fast, buffer when host lags
// - Occupancy readable as integer percent 0 to 100
// - Full buffer means overflow; further data discarded
// - Mid-frame overflow: shorter transfer, frame marked incomplete
// - Wholly discarded frame produces no transfer at all
// - Buffer-full flag reads 1 after overflow
// - Reading the buffer-full flag clears it; the code keeps it at 1 while the supervisor stays in overflow
// - Leave overflow below exit level, default 50.0
// - In overflow, every arriving frame lost, event raised
// - Events carry frame identity and timestamp
// - Above entry level 99.5: overflow now, truncate
// - Above 80.0: overflow after frame end, no hysteresis
// - Event packet: id bits 15:0, mask 47:32
// - Truncated and lost never together in one event
package fbo_pkg;

  // Buffer shape
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;

  // Register byte addresses
  localparam logic [11:0] ADDR_FILL  = 12'h000;
  localparam logic [11:0] ADDR_FLAG  = 12'h004;
  localparam logic [11:0] ADDR_EXIT  = 12'h008;
  localparam logic [11:0] ADDR_ENTRY = 12'h00c;
  localparam logic [11:0] ADDR_SYNC  = 12'h010;
  localparam logic [11:0] ADDR_EVEN  = 12'h014;
  localparam logic [11:0] ADDR_STATE = 12'h018;

  // Levels are held in half-percent units, 0 to 200
  localparam logic [7:0]  EXIT_RST   = 8'h64;
  localparam logic [7:0]  ENTRY_RST  = 8'hc7;
  localparam logic [7:0]  SYNC_RST   = 8'ha0;

  // Event enable bits and reset value
  localparam int          EV_TRUNC   = 0;
  localparam int          EV_LOST    = 1;
  localparam int          EV_OK      = 2;
  localparam logic [2:0]  EVEN_RST   = 3'h3;

  // Event packet field positions
  localparam int          FID_LSB    = 0;
  localparam int          TRUNC_POS  = 32;
  localparam int          LOST_POS   = 33;

  // Scale factors for the occupancy arithmetic
  localparam logic [11:0] HALF_FULL  = 12'h0c8;
  localparam logic [11:0] PCT_FULL   = 12'h064;
  localparam logic [11:0] DEPTH_W    = 12'h010;

  // Overflow supervisor states, Gray along run, sync, ovf
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_SYNC = 2'h1,
    ST_OVF  = 2'h3
  } ovf_state_t;

  // One buffered beat
  typedef struct packed {
    logic              pad;
    logic              incomplete;
    logic              sof;
    logic              eof;
    logic [DATA_W-1:0] data;
  } beat_t;

  // One overflow event
  typedef struct packed {
    logic [31:0] stamp;
    logic [63:0] packet;
  } event_t;

  // Unrounded occupancy strictly above a level
  function automatic logic lvl_above(logic [CNT_W-1:0] cnt, logic [7:0] lvl);
    return (12'(cnt) * HALF_FULL) > (12'(lvl) * DEPTH_W);
  endfunction

  // Unrounded occupancy strictly below a level
  function automatic logic lvl_below(logic [CNT_W-1:0] cnt, logic [7:0] lvl);
    return (12'(cnt) * HALF_FULL) < (12'(lvl) * DEPTH_W);
  endfunction

endpackage

//--- hdl/beat_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count
module beat_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Fill side
  input  wire logic                       wr_valid,
  output logic                            wr_ready,
  input  wire logic [W-1:0]               wr_data,
  // Drain side
  output logic                            rd_valid,
  input  wire logic                       rd_ready,
  output logic [W-1:0]                    rd_data,
  // Stored words
  output logic [$clog2(DEPTH):0]          count
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];  // Storage
  logic [AW:0]  wp_q;         // Write pointer, wrap bit on top
  logic [AW:0]  rp_q;         // Read pointer, wrap bit on top
  logic         do_wr;
  logic         do_rd;

  // Full when pointers differ only in the wrap bit
  assign count    = wp_q - rp_q;
  assign wr_ready = (count != (AW+1)'(DEPTH));
  assign rd_valid = (count != '0);
  assign rd_data  = mem[rp_q[AW-1:0]];
  assign do_wr    = wr_valid & wr_ready;
  assign do_rd    = rd_valid & rd_ready;

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (do_wr) wp_q <= wp_q + 1'b1;
      if (do_rd) rp_q <= rp_q + 1'b1;
    end
  end

  // Storage carries no reset
  always_ff @(posedge clk) begin
    if (do_wr) mem[wp_q[AW-1:0]] <= wr_data;
  end

endmodule // beat_fifo

//--- verif/dma_sink.sv
// DMA engine model that takes beats toward host memory and can stall
module dma_sink
  import fbo_pkg::*;
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Stall request from the bench
  input  wire logic  stall,
  // Beats from the buffer
  input  wire logic  out_valid,
  input  wire beat_t out_beat,
  output logic       out_ready
);
  beat_t got[$];  // Beats taken, in order
  // Ready trails the stall request by a cycle, as a busy host link would
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) got.push_back(out_beat);
      out_ready <= !stall;
    end
  end
endmodule // dma_sink

//--- verif/fbo_asserts.sv
// Port-level checks for the frame buffer overflow controller
module fbo_asserts
  import fbo_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Streams and events
  input wire logic        in_valid,
  input wire logic        in_sof,
  input wire logic [15:0] in_frame_id,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire beat_t       out_beat,
  input wire logic        evt_valid,
  input wire event_t      evt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states: answer in the access cycle, for one cycle only
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  apb_once_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  fill_range_a: assert property (pready && !pwrite && !pslverr && paddr == ADDR_FILL |-> prdata <= 32'h64)
    else $error("fill percent out of range");
  // A stalled beat must not change under the host
  dma_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("beat changed while stalled");
  pad_beat_a: assert property (out_valid && out_beat.pad |->
    out_beat.incomplete && out_beat.eof && out_beat.data == '0)
    else $error("closing beat malformed");
  mask_excl_a: assert property (evt_valid |-> !(evt.packet[TRUNC_POS] && evt.packet[LOST_POS]))
    else $error("truncated and lost together");
  lost_id_a: assert property (evt_valid && evt.packet[LOST_POS] |->
    $past(in_valid && in_sof) && evt.packet[15:0] == $past(in_frame_id))
    else $error("lost event without frame start");
  trunc_mid_a: assert property (evt_valid && evt.packet[TRUNC_POS] |-> $past(in_valid) && !$past(in_sof))
    else $error("truncation not mid-frame");
endmodule // fbo_asserts

bind frame_buffer_overflow_ctrl fbo_asserts fbo_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_sof(in_sof),
  .in_frame_id(in_frame_id), .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat),
  .evt_valid(evt_valid), .evt(evt));

//--- verif/frame_buffer_overflow_ctrl_test.sv
// Self-checking bench for the frame buffer overflow controller
module frame_buffer_overflow_ctrl_test import fbo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        in_valid = 1'b0;
  logic        in_sof = 1'b0;
  logic        in_eof = 1'b0;
  logic        stall = 1'b0;     // Host stall request
  logic [15:0] in_frame_id = 16'h0;
  logic [31:0] in_data = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, out_valid, out_ready, evt_valid, er;
  beat_t       out_beat;
  event_t      evt;
  event_t      evq[$];           // Events seen, in order
  int          bad_count = 0;
  int          n_compared = 0;

  frame_buffer_overflow_ctrl frame_buffer_overflow_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof), .in_frame_id(in_frame_id),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat),
    .evt_valid(evt_valid), .evt(evt));
  dma_sink dma_sink_inst (.pclk(pclk), .presetn(presetn), .stall(stall), .out_valid(out_valid),
    .out_beat(out_beat), .out_ready(out_ready));

  // 25 MHz clock
  initial forever #20 pclk = ~pclk;
  // Event pulses last one cycle, so sample every edge
  always @(posedge pclk) if (evt_valid === 1'b1) evq.push_back(evt);

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n < 20, "no pready");
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0, rd, er);
    check(rd === exp && er === 1'b0, msg);
  endtask

  // Beats carry the frame id in the top half so lost frames can be spotted
  task automatic send_frame(input logic [15:0] id, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      in_valid <= 1'b1;
      in_sof <= (i == 0);
      in_eof <= (i == len - 1);
      in_frame_id <= id;
      in_data <= {id, 16'(i)};
    end
    @(posedge pclk);
    in_valid <= 1'b0;
  endtask

  // Bounded wait for the host to collect n beats
  task automatic wait_beats(input int n);
    for (int k = 0; k < 80 && dma_sink_inst.got.size() < n; k++) @(posedge pclk);
  endtask

  function automatic logic none_of(input logic [15:0] id);
    foreach (dma_sink_inst.got[i]) if (dma_sink_inst.got[i].data[31:16] === id) return 1'b0;
    return 1'b1;
  endfunction

  task automatic reset_values();
    rd_chk(ADDR_FILL, 32'h0, "fill at reset");
    rd_chk(ADDR_FLAG, 32'h0, "flag at reset");
    rd_chk(ADDR_EXIT, 32'(EXIT_RST), "exit level at reset");
    rd_chk(ADDR_ENTRY, 32'(ENTRY_RST), "entry level at reset");
    rd_chk(ADDR_SYNC, 32'(SYNC_RST), "aligned level at reset");
    apb(1'b1, ADDR_EXIT, 32'h1b, rd, er);
    rd_chk(ADDR_EXIT, 32'h1b, "exit level write");
    apb(1'b1, ADDR_EXIT, 32'(EXIT_RST), rd, er);
    apb(1'b1, ADDR_SYNC, 32'h2a, rd, er);
    rd_chk(ADDR_SYNC, 32'h2a, "aligned level write");
    apb(1'b1, ADDR_SYNC, 32'(SYNC_RST), rd, er);
    apb(1'b1, ADDR_FILL, 32'h55, rd, er);
    rd_chk(ADDR_FILL, 32'h0, "fill is read-only");
    apb(1'b0, 12'h01c, 32'h0, rd, er);
    check(er === 1'b1 && rd === 32'h0, "unmapped read");
  endtask

  task automatic pass_frame();
    dma_sink_inst.got.delete();
    send_frame(16'h5, 4);
    wait_beats(4);
    check(dma_sink_inst.got.size() == 4 && dma_sink_inst.got[0].sof === 1'b1, "pass count");
    check(dma_sink_inst.got[3].eof === 1'b1 && dma_sink_inst.got[3].incomplete === 1'b0, "pass end");
    check(evq.size() == 0, "no event for clean frame");
  endtask

  // 13 words stored exceed 80.0 but not 99.5: whole frame kept, next lost
  task automatic aligned_entry();
    dma_sink_inst.got.delete();
    apb(1'b1, ADDR_EVEN, 32'h7, rd, er);
    stall <= 1'b1;
    send_frame(16'h6, 14);
    send_frame(16'h9, 2);
    repeat (2) @(posedge pclk);
    check(evq.size() == 2 && evq[0].packet[47:32] === 16'h0 && evq[0].packet[15:0] === 16'h6, "ok event");
    check(evq[1].packet[LOST_POS] === 1'b1 && evq[1].packet[15:0] === 16'h9, "lost event");
    rd_chk(ADDR_FILL, 32'h51, "fill rounds down");
    stall <= 1'b0;
    wait_beats(15);
    check(dma_sink_inst.got.size() == 14 && dma_sink_inst.got[13].incomplete === 1'b0, "kept whole");
    check(none_of(16'h9), "lost frame transferred");
    rd_chk(ADDR_FLAG, 32'h1, "flag after loss");
    rd_chk(ADDR_FLAG, 32'h0, "flag cleared by read");
  endtask

  // Full buffer cuts the frame; the one after is lost
  task automatic truncate_frame();
    dma_sink_inst.got.delete();
    evq.delete();
    stall <= 1'b1;
    send_frame(16'h7, 20);
    send_frame(16'h8, 1);
    repeat (2) @(posedge pclk);
    rd_chk(ADDR_FILL, 32'h64, "fill at capacity");
    rd_chk(ADDR_FLAG, 32'h1, "flag in overflow");
    check(evq.size() == 2 && evq[0].packet[TRUNC_POS] === 1'b1 && evq[0].packet[15:0] === 16'h7, "cut");
    check(evq[1].packet[LOST_POS] === 1'b1 && evq[1].packet[15:0] === 16'h8, "lost after cut");
    check(evq[1].stamp > evq[0].stamp, "stamps advance");
    stall <= 1'b0;
    wait_beats(40);
    check(dma_sink_inst.got[$].pad === 1'b1 && dma_sink_inst.got[$].incomplete === 1'b1, "incomplete end");
    check(dma_sink_inst.got.size() inside {[17:20]} && none_of(16'h8), "short transfer");
    rd_chk(ADDR_FLAG, 32'h1, "flag held during overflow");
    rd_chk(ADDR_FLAG, 32'h0, "flag cleared after exit");
  endtask

  // Entry lowered to 90.0: the cut comes at 15 stored words, while there is still room,
  // so the transfer is one data word shorter than with a full buffer
  task automatic early_entry();
    dma_sink_inst.got.delete();
    evq.delete();
    apb(1'b1, ADDR_ENTRY, 32'hb4, rd, er);
    rd_chk(ADDR_ENTRY, 32'hb4, "entry level write");
    stall <= 1'b1;
    send_frame(16'ha, 18);
    repeat (2) @(posedge pclk);
    rd_chk(ADDR_STATE, 32'h43, "status in overflow");
    check(evq.size() == 1 && evq[0].packet[TRUNC_POS] === 1'b1 && evq[0].packet[15:0] === 16'ha, "early cut");
    stall <= 1'b0;
    apb(1'b1, ADDR_ENTRY, 32'(ENTRY_RST), rd, er);
    wait_beats(40);
    check(dma_sink_inst.got.size() == 17 && dma_sink_inst.got[16].pad === 1'b1, "early short transfer");
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    pass_frame();
    aligned_entry();
    truncate_frame();
    early_entry();
    final_report();
  end

  // Watchdog, well past the expected few hundred cycles
  initial begin
    #400000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // frame_buffer_overflow_ctrl_test
